/* File: src/wdrl_top.sv */
// file: watchdog reload registers, down-counter and apb slave
// Function
// - The three reload bytes form one 24-bit reload value copied into the counter on each refresh while enabled.
// - Writing a reload byte stores it; reading it returns the matching byte of the live count.
// - The upper reload byte holds bits 23..16, resets to zero and sits at index ff1.
// - The high reload byte holds bits 15..8, resets to 04 and sits at index ff2.
// - The calibration low byte sits at index 07f, is 8 bits and survives every reset.
// - The counter counts down, reloads on refresh and then resumes counting.
// - Reaching zero raises an interrupt (irq only with its mask bit set) or a reset, chosen by the response select bit.
// - After an interrupt time-out the counter rolls to its maximum and keeps counting.
`timescale 1ns/10ps
`default_nettype none
module wdrl_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [13:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             reset_request
);
	// ****************************************
	// storage
	// ****************************************
	logic [7:0]  reload_upper_byte;
	logic [7:0]  reload_high_byte;
	logic [7:0]  reload_low_byte;
	logic [7:0]  calibration_low_byte;
	logic [7:0]  calibration_high_byte;
	logic        enable;
	logic        timeout_response_select;
	logic [1:0]  status;
	logic [1:0]  mask;
	logic [23:0] count;
	logic        tick;
	logic        refresh;
	logic        timeout;
	logic        setup;
	logic        wr;
	logic        rd;
	logic [23:0] reload_value;
	wdrl_pkg::wdrl_state_type state;

	// one-cycle access phase; pready rises one cycle after setup
	assign setup        = psel && !penable;
	assign wr           = psel && penable && pready && pwrite;
	assign rd           = setup && !pwrite;
	assign reload_value = {reload_upper_byte, reload_high_byte, reload_low_byte};
	assign refresh      = wr && (paddr == wdrl_pkg::addr_control) && pstrb[0]
		&& pwdata[wdrl_pkg::ctl_refresh_bit];
	assign timeout      = (state == wdrl_pkg::wdrl_run_s) && enable && !refresh && tick && (count == 24'h000001);

	function automatic logic hit(input logic [13:0] a, input logic [13:0] b);
		hit = (a == b);
	endfunction

	wdrl_tick i_wdrl_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick)
	);

	// ****************************************
	// apb handshake
	// ****************************************
	// ready pulses in the access cycle; no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !(hit(paddr, wdrl_pkg::addr_reload_upper)
				|| hit(paddr, wdrl_pkg::addr_reload_high) || hit(paddr, wdrl_pkg::addr_reload_low)
				|| hit(paddr, wdrl_pkg::addr_cal_low) || hit(paddr, wdrl_pkg::addr_cal_high)
				|| hit(paddr, wdrl_pkg::addr_control) || hit(paddr, wdrl_pkg::addr_status)
				|| hit(paddr, wdrl_pkg::addr_mask));
		end
	end

	// ****************************************
	// reload bytes
	// ****************************************
	// byte writes with documented resets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_upper_byte <= wdrl_pkg::rst_reload_upper;
			reload_high_byte  <= wdrl_pkg::rst_reload_high;
			reload_low_byte   <= wdrl_pkg::rst_reload_low;
		end else if (wr && pstrb[0]) begin
			// writes store the reload byte only
			if (hit(paddr, wdrl_pkg::addr_reload_upper)) begin
				reload_upper_byte <= pwdata[7:0];
			end
			if (hit(paddr, wdrl_pkg::addr_reload_high)) begin
				reload_high_byte <= pwdata[7:0];
			end
			if (hit(paddr, wdrl_pkg::addr_reload_low)) begin
				reload_low_byte <= pwdata[7:0];
			end
		end
	end

	// calibration bytes: no reset term, so they keep contents through reset
	always_ff @(posedge pclk) begin
		if (wr && pstrb[0] && hit(paddr, wdrl_pkg::addr_cal_low)) begin
			calibration_low_byte <= pwdata[7:0];
		end
		if (wr && pstrb[0] && hit(paddr, wdrl_pkg::addr_cal_high)) begin
			calibration_high_byte <= pwdata[7:0];
		end
	end

	// ****************************************
	// control, mask, status
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable                  <= 1'b0;
			timeout_response_select <= 1'b0;
			mask                    <= 2'b00;
		end else if (wr && pstrb[0]) begin
			if (hit(paddr, wdrl_pkg::addr_control)) begin
				enable                  <= pwdata[wdrl_pkg::ctl_enable_bit];
				timeout_response_select <= pwdata[wdrl_pkg::ctl_response_bit];
			end
			if (hit(paddr, wdrl_pkg::addr_mask)) begin
				mask <= pwdata[1:0];
			end
		end
	end

	// sticky events; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= 2'b00;
		end else begin
			status <= (status & ~((wr && pstrb[0] && hit(paddr, wdrl_pkg::addr_status)) ? pwdata[1:0] : 2'b00))
				| {timeout && timeout_response_select, timeout && !timeout_response_select};
		end
	end

	// interrupt path through mask, reset path as a level request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq           <= 1'b0;
			reset_request <= 1'b0;
		end else begin
			irq           <= |(status & mask);
			reset_request <= status[wdrl_pkg::st_reset_bit];
		end
	end

	// ****************************************
	// down-counter
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= wdrl_pkg::wdrl_idle_type_s;
			count <= {wdrl_pkg::rst_reload_upper, wdrl_pkg::rst_reload_high, wdrl_pkg::rst_reload_low};
		end else begin
			case (state)
				wdrl_pkg::wdrl_idle_type_s: begin
					// first enable loads the reload value
					if (enable) begin
						count <= reload_value;
						state <= wdrl_pkg::wdrl_run_s;
					end
				end
				wdrl_pkg::wdrl_run_s: begin
					if (refresh) begin
						count <= reload_value;
					end else if (!enable) begin
						state <= wdrl_pkg::wdrl_idle_type_s;
					end else if (timeout && timeout_response_select) begin
						count <= wdrl_pkg::count_zero;
						state <= wdrl_pkg::wdrl_roll_s;
					end else if (timeout) begin
						// roll to max, no automatic reload
						count <= wdrl_pkg::count_max;
					end else if (tick) begin
						count <= count - 24'h000001;
					end
				end
				wdrl_pkg::wdrl_roll_s: begin
					// reset response: hold at zero until refresh or disable
					if (refresh) begin
						count <= reload_value;
						state <= wdrl_pkg::wdrl_run_s;
					end else if (!enable) begin
						state <= wdrl_pkg::wdrl_idle_type_s;
					end
				end
				default: begin
					state <= wdrl_pkg::wdrl_idle_type_s;
				end
			endcase
		end
	end

	// ****************************************
	// read data
	// ****************************************
	// reload addresses return live count bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd) begin
			prdata <= 32'h00000000;
			if (hit(paddr, wdrl_pkg::addr_reload_upper)) prdata[7:0] <= count[23:16];
			if (hit(paddr, wdrl_pkg::addr_reload_high))  prdata[7:0] <= count[15:8];
			if (hit(paddr, wdrl_pkg::addr_reload_low))   prdata[7:0] <= count[7:0];
			if (hit(paddr, wdrl_pkg::addr_cal_low))      prdata[7:0] <= calibration_low_byte;
			if (hit(paddr, wdrl_pkg::addr_cal_high))     prdata[7:0] <= calibration_high_byte;
			if (hit(paddr, wdrl_pkg::addr_control))      prdata[1:0] <= {timeout_response_select, enable};
			if (hit(paddr, wdrl_pkg::addr_status))       prdata[1:0] <= status;
			if (hit(paddr, wdrl_pkg::addr_mask))         prdata[1:0] <= mask;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_reload_on_refresh;
		@(posedge pclk) disable iff (!presetn)
		(refresh && state == wdrl_pkg::wdrl_run_s) |=> (count == $past(reload_value));
	endproperty
	a_reload_on_refresh: assert property (p_reload_on_refresh) else $error("refresh did not reload");

	property p_read_count;
		@(posedge pclk) disable iff (!presetn)
		(rd && paddr == wdrl_pkg::addr_reload_low) |=> (prdata[7:0] == $past(count[7:0]));
	endproperty
	a_read_count: assert property (p_read_count) else $error("read did not return count");

	property p_write_upper;
		@(posedge pclk) disable iff (!presetn)
		(wr && pstrb[0] && paddr == wdrl_pkg::addr_reload_upper) |=> (reload_upper_byte == $past(pwdata[7:0]));
	endproperty
	a_write_upper: assert property (p_write_upper) else $error("upper byte not written");

	property p_write_high;
		@(posedge pclk) disable iff (!presetn)
		(wr && pstrb[0] && paddr == wdrl_pkg::addr_reload_high) |=> (reload_high_byte == $past(pwdata[7:0]));
	endproperty
	a_write_high: assert property (p_write_high) else $error("high byte not written");

	property p_write_cal;
		@(posedge pclk)
		(wr && pstrb[0] && paddr == wdrl_pkg::addr_cal_low) |=> (calibration_low_byte == $past(pwdata[7:0]));
	endproperty
	a_write_cal: assert property (p_write_cal) else $error("calibration byte not written");

	property p_count_down;
		@(posedge pclk) disable iff (!presetn)
		(state == wdrl_pkg::wdrl_run_s && enable && tick && !refresh && !timeout) |=> (count == $past(count) - 24'h000001);
	endproperty
	a_count_down: assert property (p_count_down) else $error("counter did not decrement");

	sequence s_int_timeout;
		timeout && !timeout_response_select && !refresh && enable;
	endsequence
	property p_rollover;
		@(posedge pclk) disable iff (!presetn)
		s_int_timeout |=> (count == wdrl_pkg::count_max) && status[wdrl_pkg::st_timeout_bit];
	endproperty
	a_rollover: assert property (p_rollover) else $error("no rollover after interrupt timeout");

	property p_reset_response;
		@(posedge pclk) disable iff (!presetn)
		(timeout && timeout_response_select && enable && !refresh) |=> ##1 reset_request;
	endproperty
	a_reset_response: assert property (p_reset_response) else $error("no reset request on timeout");

	property p_low_write;
		@(posedge pclk) disable iff (!presetn)
		(wr && pstrb[0] && paddr == wdrl_pkg::addr_reload_low) |=> (reload_low_byte == $past(pwdata[7:0]));
	endproperty
	a_low_write: assert property (p_low_write) else $error("low byte not written");
endmodule
`default_nettype wire

/* File: src/wdrl_pkg.sv */
// package: register map, reset values and timing for the watchdog reload block
package wdrl_pkg;
	// register indices; the apb byte address is the index times four
	localparam logic [11:0] idx_reload_upper    = 12'hff1;
	localparam logic [11:0] idx_reload_high     = 12'hff2;
	localparam logic [11:0] idx_reload_low      = 12'hff3;
	localparam logic [11:0] idx_cal_low         = 12'h07f;
	localparam logic [11:0] idx_cal_high        = 12'h07e;
	localparam logic [11:0] idx_control         = 12'hff0;
	localparam logic [11:0] idx_status          = 12'hff4;
	localparam logic [11:0] idx_mask            = 12'hff5;
	localparam logic [13:0] addr_reload_upper   = {idx_reload_upper, 2'b00};
	localparam logic [13:0] addr_reload_high    = {idx_reload_high, 2'b00};
	localparam logic [13:0] addr_reload_low     = {idx_reload_low, 2'b00};
	localparam logic [13:0] addr_cal_low        = {idx_cal_low, 2'b00};
	localparam logic [13:0] addr_cal_high       = {idx_cal_high, 2'b00};
	localparam logic [13:0] addr_control        = {idx_control, 2'b00};
	localparam logic [13:0] addr_status         = {idx_status, 2'b00};
	localparam logic [13:0] addr_mask           = {idx_mask, 2'b00};
	// reset values
	localparam logic [7:0]  rst_reload_upper    = 8'h00;
	localparam logic [7:0]  rst_reload_high     = 8'h04;
	localparam logic [7:0]  rst_reload_low      = 8'h00;
	localparam logic [23:0] count_max           = 24'hffffff;
	localparam logic [23:0] count_zero          = 24'h000000;
	localparam logic [23:0] reload_min          = 24'h000004;
	// control bit positions
	localparam int          ctl_enable_bit      = 0;
	localparam int          ctl_response_bit    = 1;
	localparam int          ctl_refresh_bit     = 2;
	// status bit positions
	localparam int          st_timeout_bit      = 0;
	localparam int          st_reset_bit        = 1;
	// tick divider: count once per this many pclk cycles
	localparam logic [7:0]  tick_div            = 8'h04;
	// counter states
	typedef enum logic [1:0] {
		wdrl_idle_type_s = 2'b00,
		wdrl_run_s       = 2'b01,
		wdrl_roll_s      = 2'b10
	} wdrl_state_type;
endpackage

/* File: src/wdrl_tick.sv */
// file: prescaler producing the watchdog count tick
`timescale 1ns/10ps
`default_nettype none
module wdrl_tick (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      tick
);
	logic [7:0] div_cnt;

	// free running divider; one pulse per period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 8'h00;
			tick    <= 1'b0;
		end else if (div_cnt == wdrl_pkg::tick_div - 8'h01) begin
			div_cnt <= 8'h00;
			tick    <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 8'h01;
			tick    <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// testbench: apb-driven checks of the watchdog reload registers and counter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [13:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        reset_request;
	logic [31:0] rd;
	logic        err;
	int          fails;
	int          comparisons;

	wdrl_top i_wdrl_top (
		.pclk          (pclk),
		.presetn       (presetn),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.pstrb         (pstrb),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.irq           (irq),
		.reset_request (reset_request)
	);

	// 250 mhz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// ************************************************************
	// bus tasks and comparison
	// ************************************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen high
	task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) fails++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [13:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdchk(input logic [13:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	// poll status until a flag sets; bounded so a dead counter cannot hang us
	task poll(input int b);
		int n;
		n = 0;
		do begin
			apb(1'b0, wdrl_pkg::addr_status, 32'h0);
			n++;
		end while (rd[b] !== 1'b1 && n < 300);
		if (n >= 300) fails++;
	endtask

	// irq is registered, so look one edge after the write lands
	task settle;
		@(posedge pclk);
		#1;
	endtask

	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		#40000;
		fails++;
		results;
	end

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 14'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		fails = 0;
		comparisons = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// idle count after reset mirrors reload reset values
		rdchk(wdrl_pkg::addr_reload_upper, 32'h00);
		rdchk(wdrl_pkg::addr_reload_high, 32'h04);
		rdchk(wdrl_pkg::addr_reload_low, 32'h00);
		wr(wdrl_pkg::addr_cal_high, 32'h00);
		wr(wdrl_pkg::addr_cal_low, 32'h20);
		// write with lane 0 strobe low must be ignored
		pstrb <= 4'h0;
		wr(wdrl_pkg::addr_cal_low, 32'h55);
		pstrb <= 4'hf;
		// calibrated load, value kept above four
		wr(wdrl_pkg::addr_reload_upper, 32'h00);
		apb(1'b0, wdrl_pkg::addr_cal_high, 32'h0);
		wr(wdrl_pkg::addr_reload_high, rd);
		apb(1'b0, wdrl_pkg::addr_cal_low, 32'h0);
		check(rd, 32'h20);
		wr(wdrl_pkg::addr_reload_low, rd);
		// reads still give the idle count, not the stored bytes
		rdchk(wdrl_pkg::addr_reload_low, 32'h00);
		rdchk(wdrl_pkg::addr_reload_high, 32'h04);
		// enable in interrupt mode loads 000020 and counts down
		wr(wdrl_pkg::addr_control, 32'h1);
		apb(1'b0, wdrl_pkg::addr_reload_low, 32'h0);
		check({31'h0, (rd <= 32'h20 && rd >= 32'h18)}, 32'h1);
		rdchk(wdrl_pkg::addr_reload_upper, 32'h00);
		poll(wdrl_pkg::st_timeout_bit);
		rdchk(wdrl_pkg::addr_reload_upper, 32'hff);
		// count must keep moving down from its maximum
		apb(1'b0, wdrl_pkg::addr_reload_low, 32'h0);
		check({31'h0, (rd < 32'hff && rd > 32'he0)}, 32'h1);
		check({31'h0, irq}, 32'h0);
		wr(wdrl_pkg::addr_mask, 32'h1);
		settle;
		check({31'h0, irq}, 32'h1);
		wr(wdrl_pkg::addr_status, 32'h1);
		settle;
		check({31'h0, irq}, 32'h0);
		// refresh pulls the count back to the reload value
		wr(wdrl_pkg::addr_control, 32'h5);
		rdchk(wdrl_pkg::addr_reload_upper, 32'h00);
		apb(1'b0, wdrl_pkg::addr_reload_low, 32'h0);
		check({31'h0, (rd <= 32'h20 && rd >= 32'h18)}, 32'h1);
		// reset response: request held, count parked at zero
		wr(wdrl_pkg::addr_control, 32'h3);
		poll(wdrl_pkg::st_reset_bit);
		check({31'h0, reset_request}, 32'h1);
		rdchk(wdrl_pkg::addr_reload_low, 32'h00);
		check({31'h0, irq}, 32'h0);
		wr(wdrl_pkg::addr_mask, 32'h3);
		settle;
		check({31'h0, irq}, 32'h1);
		wr(wdrl_pkg::addr_status, 32'h2);
		settle;
		check({31'h0, reset_request}, 32'h0);
		check({31'h0, irq}, 32'h0);
		// unmapped address is refused
		apb(1'b0, 14'h0100, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		// second reset: calibration survives, reload bytes return to defaults
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(wdrl_pkg::addr_cal_low, 32'h20);
		rdchk(wdrl_pkg::addr_reload_high, 32'h04);
		rdchk(wdrl_pkg::addr_reload_upper, 32'h00);
		results;
	end
endmodule
`default_nettype wire
